/* File: pkg/lape_consts.svh */
// register offsets, field positions, reset values and timing counts
`ifndef LAPE_CONSTS_SVH
`define LAPE_CONSTS_SVH
`define LAPE_OFS_CTRL      12'h000
`define LAPE_OFS_STATUS    12'h004
`define LAPE_CTRL_LINK     0
`define LAPE_CTRL_BUSY     1
`define LAPE_CTRL_DATA     2
`define LAPE_ST_STATE      0
`define LAPE_ST_SELFBUSY   2
`define LAPE_ST_REJ        3
`define LAPE_ST_ACKPEND    4
`define LAPE_ST_PEERBUSY   5
`define LAPE_ST_TREC       6
`define LAPE_ST_VS         8
`define LAPE_ST_VA         12
`define LAPE_ST_VR         16
`define LAPE_ST_RC         20
`define LAPE_ST_SEVERE     24
`define LAPE_CTRL_RST      3'h0
`define LAPE_SEQ_RST       3'h0
`define LAPE_WINDOW_K      3'h4
`define LAPE_RETRY_LIMIT   3'h3
`define LAPE_EST_MS        2000
`define LAPE_RTX_MS        1000
`define LAPE_CLK_HZ        50000000
`define LAPE_TICK_CYCLES   (`LAPE_CLK_HZ / 1000)
`define LAPE_CTRL_LINK_RESET_COMMAND     8'h2F
`define LAPE_CTRL_UA       8'h63
`define LAPE_PF_MASK       8'hEF
`endif

/* File: pkg/lape_pkg.sv */
// types shared by the link access protocol engine
`default_nettype none
package lape_pkg;
	typedef enum logic [1:0] {
		lape_idle   = 2'b00,
		lape_await  = 2'b01,
		lape_active = 2'b10
	} lape_state_t;
	typedef enum logic [1:0] {
		lape_rr  = 2'b00,
		lape_rnr = 2'b01,
		lape_rej = 2'b10
	} lape_skind_t;
endpackage
`default_nettype wire

/* File: core/lape_engine.sv */
// link access protocol engine: windowed sender, receiver, timer, apb regs
// Notes on behaviour
// R1 - rr means own receiver free, rnr busy, rej new reject and free
// R2 - reset command only for establishment and re-establishment, ack only answers it
// R3 - new link flag on reset command and ack; more bit always zero
// R4 - sent command has c/r 0, response 1; received command has 1
// R5 - states idle, awaiting link and active
// R6 - self busy set by higher layer only; discards information frames
// R7 - out of sequence frame sets reject and is dropped; in sequence clears
// R8 - ack pending set on accept, cleared once acknowledged
// R9 - peer busy set by rnr, cleared by rr or rej
// R10 - establish 2.0 s and retransmit 1.0 s share one counter
// R11 - start of running timer ignored; stop resets; restart is both
// R12 - send, ack and receive variables are 3 bits, wrap modulo 8
// R13 - at most four unacknowledged information frames
// R14 - window sending only when active, peer free, no timer recovery
// R15 - frame carries send variable, which then increments; timer starts
// R16 - ack number outside ack..send span forces re-establishment
// R17 - new ack updates ack variable, stops timer, restarts if pending
// R18 - rnr stops sending and starts timer; rr or rej resume
// R19 - rej loads send variable from its ack number for resend
// R20 - retransmit expiry enters recovery, polls, restarts timer
// R21 - recovery blocks sending; final response reloads both variables
// R22 - further expiry counts retries; beyond three re-establishes
// R23 - re-establish sends polled reset command, zeroes all state
// R24 - start idle with zero variables and clear conditions
// R25 - in sequence frame while free is delivered, receive var increments
// R26 - retry count cleared on entering or leaving recovery and on reset
// R27 - timer periods come from a prescaled tick with parameter reloads
`timescale 1ns/1ns
`default_nettype none
`include "lape_consts.svh"
module lape_engine #(
	parameter int          TICK_CYCLES = `LAPE_TICK_CYCLES,
	parameter logic [11:0] EST_TICKS   = 12'(`LAPE_EST_MS),
	parameter logic [11:0] RTX_TICKS   = 12'(`LAPE_RTX_MS)
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_ctrl,
	input  wire logic        rx_cr,
	output var  logic        rx_deliver,
	output var  logic [2:0]  rx_deliver_seq,
	output var  logic        tx_valid,
	input  wire logic        tx_ready,
	output var  logic [7:0]  tx_ctrl,
	output var  logic        tx_cr,
	output var  logic        tx_nlf,
	output var  logic        tx_more
);
	lape_pkg::lape_state_t st_q;
	logic [2:0]  vs_q, va_q, vr_q, rc_q;
	logic        sb_q, sb_prev_q, rej_q, ackp_q, pbusy_q, trec_q, sev_q;
	logic [2:0]  ctrl_q;
	logic        p_ua_q, p_link_reset_command_q, p_sup_q, p_poll_q;
	logic [1:0]  p_kind_q;
	logic        p_pf_q, p_cmd_q;
	logic        tx_valid_q, tx_cr_q, tx_nlf_q, deliv_q;
	logic [7:0]  tx_ctrl_q;
	logic [2:0]  deliv_seq_q;
	logic [31:0] prdata_q;
	logic [15:0] pre_q;
	logic        tick, run_q, tmo;
	logic [11:0] cnt_q;
	logic        t_stop, t_start, t_est;

	// modulo 8 distance from b up to a
	function automatic logic [2:0] sdiff(input logic [2:0] a,
		input logic [2:0] b);
		sdiff = a - b;
	endfunction

	// supervisory control byte with ack number and poll/final bit
	function automatic logic [7:0] sframe(input logic [1:0] kind,
		input logic [2:0] nr, input logic pf);
		sframe = {nr, pf, kind, 2'b01};
	endfunction

	// received frame decode
	logic       rx_i, rx_rr, rx_rnr, rx_rej, rx_sup, rx_link_reset_command, rx_ua;
	logic       rx_pf, has_nr, nr_ok, act, reest, go_await;
	logic [2:0] rx_nr, rx_ns;
	assign rx_i    = rx_valid && !rx_ctrl[0];
	assign rx_sup  = rx_valid && (rx_ctrl[1:0] == 2'b01);
	assign rx_rr   = rx_sup && (rx_ctrl[3:2] == lape_pkg::lape_rr);
	assign rx_rnr  = rx_sup && (rx_ctrl[3:2] == lape_pkg::lape_rnr);
	assign rx_rej  = rx_sup && (rx_ctrl[3:2] == lape_pkg::lape_rej);
	assign rx_link_reset_command = rx_valid && rx_cr &&
		((rx_ctrl & `LAPE_PF_MASK) == `LAPE_CTRL_LINK_RESET_COMMAND); // [R2] [R4]
	assign rx_ua   = rx_valid && !rx_cr &&
		((rx_ctrl & `LAPE_PF_MASK) == `LAPE_CTRL_UA);
	assign rx_pf   = rx_ctrl[4];
	assign rx_nr   = rx_ctrl[7:5];
	assign rx_ns   = rx_ctrl[3:1];
	assign has_nr  = rx_i || rx_rr || rx_rnr || rx_rej;
	// ack number must lie between ack and send variables [R16] [R12]
	assign nr_ok   = sdiff(rx_nr, va_q) <= sdiff(vs_q, va_q);
	assign act     = (st_q == lape_pkg::lape_active) && !rx_link_reset_command;
	assign reest   = act && ((has_nr && !nr_ok) ||
		(tmo && trec_q && (rc_q == `LAPE_RETRY_LIMIT))); // [R16] [R22]
	assign go_await = (st_q == lape_pkg::lape_idle) &&
		ctrl_q[`LAPE_CTRL_LINK] && !rx_valid; // [R5]

	// transmit arbitration: unnumbered first, then supervisory and poll, then data, then a lone ack
	logic tx_free, can_i, snd_i, take_sup, take_poll, take_ack;
	logic take_ua, take_link_reset_command;
	assign tx_free   = !tx_valid_q || tx_ready;
	assign can_i     = (st_q == lape_pkg::lape_active) && !pbusy_q &&
		!trec_q && ctrl_q[`LAPE_CTRL_DATA] &&
		(sdiff(vs_q, va_q) < `LAPE_WINDOW_K); // [R13] [R14] [R18] [R21]
	assign take_ua   = tx_free && p_ua_q;
	assign take_link_reset_command = tx_free && !p_ua_q && p_link_reset_command_q;
	assign take_sup  = tx_free && !p_ua_q && !p_link_reset_command_q && p_sup_q;
	assign take_poll = tx_free && !p_ua_q && !p_link_reset_command_q && !p_sup_q &&
		p_poll_q;
	assign snd_i     = tx_free && !p_ua_q && !p_link_reset_command_q && !p_sup_q &&
		!p_poll_q && can_i && !reest;
	assign take_ack  = tx_free && !p_ua_q && !p_link_reset_command_q && !p_sup_q &&
		!p_poll_q && !can_i && ackp_q &&
		(st_q == lape_pkg::lape_active);

	// millisecond tick; one prescaler keeps the period counter narrow [R27]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q <= 16'h0000;
		end else if (pre_q == 16'(TICK_CYCLES - 1)) begin
			pre_q <= 16'h0000;
		end else begin
			pre_q <= pre_q + 16'h0001;
		end
	end
	assign tick = (pre_q == 16'(TICK_CYCLES - 1));
	assign tmo  = run_q && tick && (cnt_q == 12'h001); // [R11]

	// timer commands; stop plus start in one cycle is a restart [R11]
	always_comb begin
		t_stop  = 1'b0;
		t_start = 1'b0;
		t_est   = 1'b0;
		if (rx_link_reset_command) begin
			t_stop = 1'b1;
		end else if (reest || go_await) begin
			t_stop  = 1'b1; // [R23]
			t_start = 1'b1;
			t_est   = 1'b1;
		end else if (st_q == lape_pkg::lape_await) begin
			if (rx_ua) begin
				t_stop = 1'b1;
			end else if (tmo) begin
				t_start = 1'b1; // repeat the reset command
				t_est   = 1'b1;
			end
		end else if (st_q == lape_pkg::lape_active) begin
			if (tmo) begin
				t_start = 1'b1; // [R20] [R22]
			end else if (has_nr) begin
				if (trec_q) begin
					if (rx_sup && rx_pf && !rx_cr) begin
						t_stop  = 1'b1; // [R21]
						t_start = rx_nr != vs_q;
					end
				end else if (rx_nr != va_q) begin
					t_stop  = 1'b1; // [R17]
					t_start = rx_nr != vs_q;
				end
				if (rx_rnr) begin
					t_start = 1'b1; // [R18]
				end
			end
			if (snd_i) begin
				t_start = 1'b1; // [R15]
			end
		end
	end

	// single shared period counter for both timeouts [R10]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_q <= 1'b0;
			cnt_q <= 12'h000;
		end else if (t_start && (t_stop || tmo || !run_q)) begin
			run_q <= 1'b1; // [R11]
			cnt_q <= t_est ? EST_TICKS : RTX_TICKS;
		end else if (t_stop || tmo) begin
			run_q <= 1'b0;
			cnt_q <= 12'h000;
		end else if (run_q && tick) begin
			cnt_q <= cnt_q - 12'h001;
		end
	end

	// link state, sequence variables and conditions
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q      <= lape_pkg::lape_idle; // [R24]
			vs_q      <= `LAPE_SEQ_RST;
			va_q      <= `LAPE_SEQ_RST;
			vr_q      <= `LAPE_SEQ_RST;
			rc_q      <= `LAPE_SEQ_RST;
			rej_q     <= 1'b0;
			ackp_q    <= 1'b0;
			pbusy_q   <= 1'b0;
			trec_q    <= 1'b0;
			sb_prev_q <= 1'b0;
			p_ua_q    <= 1'b0;
			p_link_reset_command_q  <= 1'b0;
			p_sup_q   <= 1'b0;
			p_poll_q  <= 1'b0;
			p_kind_q  <= lape_pkg::lape_rr;
			p_pf_q    <= 1'b0;
			p_cmd_q   <= 1'b0;
		end else begin
			sb_prev_q <= sb_q;
			// clear what was sent first; later sets win
			if (take_ua) p_ua_q <= 1'b0;
			if (take_link_reset_command) p_link_reset_command_q <= 1'b0;
			if (take_sup) p_sup_q <= 1'b0;
			if (take_poll) p_poll_q <= 1'b0;
			if (take_sup || take_poll || snd_i || take_ack) begin
				ackp_q <= 1'b0; // [R8]
			end
			if (snd_i) begin
				vs_q <= vs_q + 3'h1; // [R15] [R12]
			end
			// self busy change is told to the peer as a command [R1]
			if (act && (sb_q != sb_prev_q)) begin
				p_sup_q  <= 1'b1;
				p_kind_q <= sb_q ? lape_pkg::lape_rnr : lape_pkg::lape_rr;
				p_pf_q   <= 1'b0;
				p_cmd_q  <= 1'b1;
			end
			case (st_q)
				lape_pkg::lape_idle: begin
					if (rx_i && rx_pf && rx_cr) begin
						st_q     <= lape_pkg::lape_active; // peer opens
						p_sup_q  <= 1'b1;
						p_kind_q <= sb_q ? lape_pkg::lape_rnr :
							lape_pkg::lape_rr;
						p_pf_q   <= 1'b1;
						p_cmd_q  <= 1'b0;
					end else if (go_await) begin
						st_q     <= lape_pkg::lape_await; // [R5]
						p_link_reset_command_q <= 1'b1;
					end
				end
				lape_pkg::lape_await: begin
					if (rx_ua) begin
						st_q <= lape_pkg::lape_active;
					end else if (tmo) begin
						p_link_reset_command_q <= 1'b1;
					end
				end
				lape_pkg::lape_active: begin
					if (reest) begin
						st_q     <= lape_pkg::lape_await; // [R23]
						p_link_reset_command_q <= 1'b1;
						p_sup_q  <= 1'b0;
						p_poll_q <= 1'b0;
						vs_q     <= `LAPE_SEQ_RST;
						va_q     <= `LAPE_SEQ_RST;
						vr_q     <= `LAPE_SEQ_RST;
						rc_q     <= `LAPE_SEQ_RST; // [R26]
						rej_q    <= 1'b0;
						ackp_q   <= 1'b0;
						pbusy_q  <= 1'b0;
						trec_q   <= 1'b0;
					end else if (tmo) begin
						p_poll_q <= 1'b1; // [R20]
						if (!trec_q) begin
							trec_q <= 1'b1;
							rc_q   <= `LAPE_SEQ_RST; // [R26]
						end else begin
							rc_q <= rc_q + 3'h1; // [R22]
						end
					end
					if (!reest && has_nr) begin
						if (trec_q && rx_sup && rx_pf && !rx_cr) begin
							trec_q <= 1'b0; // [R21] [R26]
							rc_q   <= `LAPE_SEQ_RST;
							va_q   <= rx_nr;
							vs_q   <= rx_nr;
						end else begin
							va_q <= rx_nr; // [R17] [R21]
							if (rx_rej && !trec_q) begin
								vs_q <= rx_nr; // [R19]
							end
						end
						if (rx_rnr) begin
							pbusy_q <= 1'b1; // [R9] [R18]
						end else if (rx_rr || rx_rej) begin
							pbusy_q <= 1'b0; // [R9]
						end
					end
					// receiver side of information frames
					if (!reest && rx_i && !sb_q) begin // [R6]
						if (rx_ns == vr_q) begin
							vr_q   <= vr_q + 3'h1; // [R25]
							rej_q  <= 1'b0; // [R7]
							ackp_q <= 1'b1; // [R8]
						end else begin
							rej_q    <= 1'b1; // [R7]
							p_sup_q  <= 1'b1;
							p_kind_q <= rej_q ? lape_pkg::lape_rr :
								lape_pkg::lape_rej; // [R1]
							p_pf_q   <= 1'b0;
							p_cmd_q  <= 1'b0;
						end
					end
					// answer a poll with the final bit
					if (!reest && (rx_rr || rx_rnr || rx_i) &&
						rx_cr && rx_pf) begin
						p_sup_q  <= 1'b1;
						p_kind_q <= sb_q ? lape_pkg::lape_rnr :
							lape_pkg::lape_rr;
						p_pf_q   <= 1'b1;
						p_cmd_q  <= 1'b0;
					end
				end
				default: begin
					st_q <= lape_pkg::lape_idle;
				end
			endcase
			// peer reset: zero everything and answer with the ack [R23]
			if (rx_link_reset_command) begin
				st_q     <= lape_pkg::lape_active;
				p_ua_q   <= 1'b1; // [R2]
				p_link_reset_command_q <= 1'b0;
				p_sup_q  <= 1'b0;
				p_poll_q <= 1'b0;
				vs_q     <= `LAPE_SEQ_RST;
				va_q     <= `LAPE_SEQ_RST;
				vr_q     <= `LAPE_SEQ_RST;
				rc_q     <= `LAPE_SEQ_RST;
				rej_q    <= 1'b0;
				ackp_q   <= 1'b0;
				pbusy_q  <= 1'b0;
				trec_q   <= 1'b0;
			end
		end
	end

	// transmit frame register; held until the framer takes it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_valid_q <= 1'b0;
			tx_ctrl_q  <= 8'h00;
			tx_cr_q    <= 1'b0;
			tx_nlf_q   <= 1'b0;
		end else if (tx_free) begin
			tx_valid_q <= take_ua || take_link_reset_command || take_sup || take_poll ||
				snd_i || take_ack;
			tx_nlf_q   <= take_ua || take_link_reset_command; // [R3]
			if (take_ua) begin
				tx_ctrl_q <= `LAPE_CTRL_UA | 8'h10; // [R23]
				tx_cr_q   <= 1'b1; // [R4]
			end else if (take_link_reset_command) begin
				tx_ctrl_q <= `LAPE_CTRL_LINK_RESET_COMMAND | 8'h10; // [R23]
				tx_cr_q   <= 1'b0; // [R4]
			end else if (take_sup) begin
				tx_ctrl_q <= sframe(p_kind_q, vr_q, p_pf_q);
				tx_cr_q   <= !p_cmd_q; // [R4]
			end else if (take_poll) begin
				tx_ctrl_q <= sframe(sb_q ? lape_pkg::lape_rnr :
					lape_pkg::lape_rr, vr_q, 1'b1); // [R20]
				tx_cr_q   <= 1'b0;
			end else if (snd_i) begin
				tx_ctrl_q <= {vr_q, 1'b0, vs_q, 1'b0}; // [R15]
				tx_cr_q   <= 1'b0;
			end else begin
				tx_ctrl_q <= sframe(sb_q ? lape_pkg::lape_rnr :
					lape_pkg::lape_rr, vr_q, 1'b0);
				tx_cr_q   <= 1'b1;
			end
		end
	end
	assign tx_valid = tx_valid_q;
	assign tx_ctrl  = tx_ctrl_q;
	assign tx_cr    = tx_cr_q;
	assign tx_nlf   = tx_nlf_q;
	assign tx_more  = 1'b0; // no split frames [R3]

	// delivery strobe to the higher layer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			deliv_q     <= 1'b0;
			deliv_seq_q <= 3'h0;
		end else begin
			deliv_q     <= act && !reest && rx_i && !sb_q &&
				(rx_ns == vr_q); // [R25]
			deliv_seq_q <= rx_ns;
		end
	end
	assign rx_deliver     = deliv_q;
	assign rx_deliver_seq = deliv_seq_q;

	// apb slave, zero wait; unmapped addresses answer with an error
	logic setup, wr, hit_ctrl, hit_st;
	assign setup    = psel && !penable;
	assign wr       = psel && penable && pwrite;
	assign hit_ctrl = paddr == `LAPE_OFS_CTRL;
	assign hit_st   = paddr == `LAPE_OFS_STATUS;
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !hit_ctrl && !hit_st;
	assign sb_q     = ctrl_q[`LAPE_CTRL_BUSY]; // [R6]

	// control register: only software moves self busy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `LAPE_CTRL_RST;
		end else if (wr && hit_ctrl) begin
			ctrl_q <= pwdata[2:0];
		end
	end

	// severe error sticky; a new error beats the write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sev_q <= 1'b0;
		end else if (reest) begin
			sev_q <= 1'b1;
		end else if (wr && hit_st && pwdata[`LAPE_ST_SEVERE]) begin
			sev_q <= 1'b0;
		end
	end

	// read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
		end else if (setup && !pwrite) begin
			prdata_q <= 32'h00000000;
			if (hit_ctrl) begin
				prdata_q[2:0] <= ctrl_q;
			end else if (hit_st) begin
				prdata_q[1:0]                 <= st_q;
				prdata_q[`LAPE_ST_SELFBUSY]   <= sb_q;
				prdata_q[`LAPE_ST_REJ]        <= rej_q;
				prdata_q[`LAPE_ST_ACKPEND]    <= ackp_q;
				prdata_q[`LAPE_ST_PEERBUSY]   <= pbusy_q;
				prdata_q[`LAPE_ST_TREC]       <= trec_q;
				prdata_q[`LAPE_ST_VS +: 3]    <= vs_q;
				prdata_q[`LAPE_ST_VA +: 3]    <= va_q;
				prdata_q[`LAPE_ST_VR +: 3]    <= vr_q;
				prdata_q[`LAPE_ST_RC +: 3]    <= rc_q;
				prdata_q[`LAPE_ST_SEVERE]     <= sev_q;
			end
		end
	end
	assign prdata = prdata_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_nlf_only: assert property (tx_valid_q && tx_nlf_q |-> // [R3]
		((tx_ctrl_q & `LAPE_PF_MASK) == `LAPE_CTRL_LINK_RESET_COMMAND) ||
		((tx_ctrl_q & `LAPE_PF_MASK) == `LAPE_CTRL_UA))
		else $error("new link flag on wrong frame");
	chk_cr_reset: assert property (take_link_reset_command |=> !tx_cr_q && tx_nlf_q) // [R4]
		else $error("reset command with wrong c/r or flag");
	chk_window_size: assert property (sdiff(vs_q, va_q) <= 3'h4) // [R13]
		else $error("send window exceeded");
	chk_send_gate: assert property (snd_i |-> !pbusy_q && !trec_q && // [R14]
		st_q == lape_pkg::lape_active)
		else $error("information frame sent while blocked");
	chk_seq_step: assert property (snd_i && !rx_valid && !tmo |=> // [R15]
		vs_q == $past(vs_q) + 3'h1 && tx_ctrl_q[3:1] == $past(vs_q))
		else $error("send variable not stepped");
	chk_busy_drop: assert property (rx_i && sb_q |=> !rx_deliver) // [R6]
		else $error("frame delivered while busy");
	chk_retry_cap: assert property (rc_q <= `LAPE_RETRY_LIMIT) // [R22]
		else $error("retry count beyond limit");
	chk_peer_busy: assert property (act && rx_rnr && !reest |=> // [R9]
		pbusy_q && !snd_i)
		else $error("rnr did not set peer busy");
	chk_reest_zero: assert property (reest |=> vs_q == 3'h0 && // [R23]
		va_q == 3'h0 && vr_q == 3'h0 && !trec_q && p_link_reset_command_q)
		else $error("re-establishment left state");
endmodule
`default_nettype wire

/* File: verification/lape_host_model.sv */
// host side peer model: feeds frames to the engine and takes its frames
`timescale 1ns/1ns
`default_nettype none
module lape_host_model (
	input  wire logic       pclk,
	output var  logic       rx_valid,
	output var  logic [7:0] rx_ctrl,
	output var  logic       rx_cr,
	input  wire logic       tx_valid,
	output var  logic       tx_ready,
	input  wire logic [7:0] tx_ctrl,
	input  wire logic       tx_cr,
	input  wire logic       tx_nlf,
	input  wire logic       tx_more
);
	logic [10:0] q[$];
	logic        stall;
	// quiet lines until the first frame
	initial begin
		rx_valid = 1'b0;
		rx_ctrl = 8'h00;
		rx_cr = 1'b0;
		tx_ready = 1'b0;
		stall = 1'b0;
	end
	// one frame per call; idle lines show the inverse so no stale match
	// host commands carry c/r 1 and responses 0
	task automatic send(input logic [7:0] c, input logic cr);
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx_ctrl <= c;
		rx_cr <= cr;
		@(posedge pclk);
		rx_valid <= 1'b0;
		rx_ctrl <= ~c;
		rx_cr <= ~cr;
	endtask
	// a stall holds ready low, as a slow framer would
	always @(posedge pclk) tx_ready <= !stall;
	// every taken frame is queued whole with its address flags
	always @(posedge pclk) begin
		if (tx_valid && tx_ready)
			q.push_back({tx_more, tx_nlf, tx_cr, tx_ctrl});
	end
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench for the link access protocol engine
`timescale 1ns/1ns
`default_nettype none
`include "lape_consts.svh"
`define CK(a, b) begin check_count++; if ((a) !== (b)) begin \
	errors++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, \
	(a), (b)); end end
module testbench;
	localparam logic [11:0] ST = `LAPE_OFS_STATUS;
	localparam logic [11:0] CT = `LAPE_OFS_CTRL;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        rx_valid, rx_cr, rx_deliver, tx_valid, tx_ready;
	logic        tx_cr, tx_nlf, tx_more, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  rx_ctrl, tx_ctrl;
	logic [2:0]  rx_deliver_seq, dseq;
	logic [10:0] f;
	int          errors, check_count, dcnt, n, np;
	// short timer counts keep expiries within a few dozen cycles
	lape_engine #(.TICK_CYCLES(4), .EST_TICKS(12'h010),
		.RTX_TICKS(12'h00C)) lape_engine_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_valid(rx_valid), .rx_ctrl(rx_ctrl),
		.rx_cr(rx_cr), .rx_deliver(rx_deliver),
		.rx_deliver_seq(rx_deliver_seq), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_ctrl(tx_ctrl), .tx_cr(tx_cr),
		.tx_nlf(tx_nlf), .tx_more(tx_more));
	lape_host_model lape_host_model_inst (.pclk(pclk),
		.rx_valid(rx_valid), .rx_ctrl(rx_ctrl), .rx_cr(rx_cr),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_ctrl(tx_ctrl),
		.tx_cr(tx_cr), .tx_nlf(tx_nlf), .tx_more(tx_more));
	// 50 MHz clock
	always #10 pclk = ~pclk;
	// deliveries to the higher layer, with the last sequence seen
	always @(posedge pclk) begin
		if (rx_deliver) begin
			dcnt <= dcnt + 1;
			dseq <= rx_deliver_seq;
		end
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// one apb transfer; waits for pready, never assumes a latency
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			errors++; // a slave that never answers counts as a miss
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask
	// next frame taken by the host; a long silence counts as a miss
	task automatic gf();
		n = 0;
		while (lape_host_model_inst.q.size() == 0 && n < 400) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 400)
			f = 11'h7FF;
		else
			f = lape_host_model_inst.q.pop_front();
	endtask
	task automatic frm(input logic [10:0] e);
		gf();
		`CK(f, e)
	endtask
	task automatic t_reset();
		apb(1'b0, ST, 32'h0);
		`CK(rd, 32'h0)
		apb(1'b0, 12'h008, 32'h0);
		`CK({er, rd}, 33'h100000000)
		apb(1'b1, ST, 32'hFFFFFFFF);
		apb(1'b0, ST, 32'h0);
		`CK(rd, 32'h0)
		$display("test reset done");
	endtask
	task automatic t_estab();
		apb(1'b1, CT, 32'h1);
		apb(1'b0, ST, 32'h0);
		`CK(rd[1:0], 2'h1)
		frm(11'h23F);
		lape_host_model_inst.send(8'h73, 1'b0);
		cyc(3);
		apb(1'b0, ST, 32'h0);
		`CK(rd, 32'h2)
		$display("test establish done");
	endtask
	task automatic t_recv();
		lape_host_model_inst.stall <= 1'b1;
		lape_host_model_inst.send(8'h00, 1'b1);
		cyc(3);
		`CK(dcnt, 1)
		`CK(dseq, 3'h0)
		// first ack sits in the stalled slot, so this one stays pending
		lape_host_model_inst.send(8'h02, 1'b1);
		cyc(2);
		apb(1'b0, ST, 32'h0);
		`CK({rd[`LAPE_ST_VR +: 3], rd[`LAPE_ST_ACKPEND]}, 4'h5)
		lape_host_model_inst.stall <= 1'b0;
		frm(11'h121);
		frm(11'h141);
		apb(1'b0, ST, 32'h0);
		`CK(rd[`LAPE_ST_ACKPEND], 1'b0)
		lape_host_model_inst.send(8'h06, 1'b1);
		frm(11'h149);
		apb(1'b0, ST, 32'h0);
		`CK(rd[`LAPE_ST_REJ], 1'b1)
		lape_host_model_inst.send(8'h06, 1'b1);
		frm(11'h141);
		lape_host_model_inst.send(8'h04, 1'b1);
		frm(11'h161);
		`CK(dseq, 3'h2)
		apb(1'b0, ST, 32'h0);
		`CK({dcnt[3:0], rd[`LAPE_ST_REJ]}, 5'h06)
		$display("test receive done");
	endtask
	task automatic t_peer();
		lape_host_model_inst.send(8'h3F, 1'b1);
		frm(11'h373);
		apb(1'b0, ST, 32'h0);
		`CK(rd, 32'h2)
		$display("test peer reset done");
	endtask
	task automatic t_busy();
		apb(1'b1, CT, 32'h3);
		frm(11'h005);
		lape_host_model_inst.send(8'h00, 1'b1);
		cyc(6);
		apb(1'b0, ST, 32'h0);
		`CK({dcnt[3:0], rd[`LAPE_ST_VR +: 3], rd[2]}, 8'h31)
		lape_host_model_inst.q.delete();
		apb(1'b1, CT, 32'h1);
		frm(11'h001);
		$display("test self busy done");
	endtask
	task automatic t_window();
		apb(1'b1, CT, 32'h5);
		for (int i = 0; i < 4; i++)
			frm({7'h00, 3'(i), 1'b0});
		cyc(6);
		`CK(lape_host_model_inst.q.size(), 0)
		apb(1'b1, CT, 32'h1);
		apb(1'b0, ST, 32'h0);
		`CK({rd[`LAPE_ST_VA +: 3], rd[`LAPE_ST_VS +: 3]}, 6'h04)
		lape_host_model_inst.send(8'h41, 1'b0);
		apb(1'b0, ST, 32'h0);
		`CK({rd[`LAPE_ST_VA +: 3], rd[`LAPE_ST_VS +: 3]}, 6'h14)
		lape_host_model_inst.send(8'h49, 1'b0);
		apb(1'b0, ST, 32'h0);
		`CK({rd[`LAPE_ST_VS +: 3], rd[`LAPE_ST_PEERBUSY]}, 4'h4)
		lape_host_model_inst.send(8'h45, 1'b0);
		apb(1'b1, CT, 32'h5);
		cyc(8);
		`CK(lape_host_model_inst.q.size(), 0)
		apb(1'b0, ST, 32'h0);
		`CK(rd[`LAPE_ST_PEERBUSY], 1'b1)
		frm(11'h011);
		apb(1'b0, ST, 32'h0);
		`CK({rd[`LAPE_ST_RC +: 3], rd[`LAPE_ST_TREC]}, 4'h1)
		lape_host_model_inst.send(8'h51, 1'b0);
		frm(11'h004);
		apb(1'b0, ST, 32'h0);
		`CK({rd[`LAPE_ST_TREC], rd[`LAPE_ST_PEERBUSY]}, 2'h0)
		$display("test window done");
	endtask
	task automatic t_retry();
		np = 0;
		f = 11'h000;
		for (int i = 0; i < 14 && f !== 11'h23F; i++) begin
			gf();
			if (f === 11'h011)
				np++;
		end
		`CK(np, 4)
		`CK(f, 11'h23F)
		apb(1'b1, CT, 32'h1);
		lape_host_model_inst.send(8'h73, 1'b0);
		cyc(2);
		apb(1'b0, ST, 32'h0);
		`CK({rd[24], rd[22:0]}, 24'h800002)
		apb(1'b1, ST, 32'h01000000);
		apb(1'b0, ST, 32'h0);
		`CK(rd[24], 1'b0)
		$display("test retry done");
	endtask
	task automatic t_badnr();
		lape_host_model_inst.send(8'hA1, 1'b0);
		frm(11'h23F);
		lape_host_model_inst.send(8'h73, 1'b0);
		cyc(2);
		apb(1'b0, ST, 32'h0);
		`CK({rd[24], rd[1:0]}, 3'h6)
		$display("test bad ack done");
	endtask
	// reset for five cycles, then the scenarios in order
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		errors = 0;
		check_count = 0;
		dcnt = 0;
		dseq = 3'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_estab();
		t_recv();
		t_peer();
		t_busy();
		t_window();
		t_retry();
		t_badnr();
		end_sim();
	end
	// watchdog well beyond the few hundred cycles the scenarios take
	initial begin
		#400000;
		errors++;
		end_sim();
	end
endmodule
`default_nettype wire
